//--- core/smc_pkg.sv
/*
 * smc_pkg: register map, mode codes and carrier types of the sleep mode controller.
 * Assumes a 32-bit APB register bus and a 25 MHz system clock.
 */
package smc_pkg;

    localparam int          APB_AW       = 8;
    localparam int          NUM_PERIPH   = 16;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_SLEEP   = 8'h04;
    localparam logic [7:0]  ADDR_PGATE   = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0C;

    // control and sleep register fields
    localparam int          CTRL_MODE_LO = 0;
    localparam int          CTRL_EN_BIT  = 3;
    localparam int          SLEEP_GO_BIT = 0;

    // status register fields
    localparam int          STAT_ST_LO   = 0;
    localparam int          STAT_MODE_LO = 4;
    localparam int          STAT_WAKE_LO = 8;

    // reset values
    localparam logic [2:0]  MODE_RESET   = 3'h0;
    localparam logic        EN_RESET     = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // sleep mode codes as written to the control register
    localparam logic [2:0]  MODE_IDLE    = 3'h0;
    localparam logic [2:0]  MODE_PDOWN   = 3'h1;
    localparam logic [2:0]  MODE_PSAVE   = 3'h2;
    localparam logic [2:0]  MODE_STDBY   = 3'h3;
    localparam logic [2:0]  MODE_ESTDBY  = 3'h4;

    typedef enum logic [1:0] {
        SMC_ACTIVE,
        SMC_SLEEP,
        SMC_RESTART
    } smc_state_t;

    // wake sources, all arriving from outside the clock domain
    typedef struct packed {
        logic two_wire_serial_interface;
        logic usb_resume;
        logic pin_change;
        logic rtc;
        logic any_irq;
    } smc_wake_t;

    localparam int          WAKE_W       = $bits(smc_wake_t);

    // enables toward the clock tree, oscillators and memories
    typedef struct packed {
        logic cpu;
        logic sram;
        logic event_sys;
        logic intc;
        logic main_osc;
        logic xtal_osc;
        logic rtc_osc;
        logic rtc;
        logic retain;
    } smc_clk_t;

    localparam smc_clk_t    CLK_ALL_ON   = '{cpu: 1'b1, sram: 1'b1, event_sys: 1'b1,
                                             intc: 1'b1, main_osc: 1'b1, xtal_osc: 1'b1,
                                             rtc_osc: 1'b1, rtc: 1'b1, retain: 1'b0};

endpackage : smc_pkg

//--- core/smc_sync.sv
/*
 * smc_sync: two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a level that stays stable for several clock cycles.
 */
`timescale 1ns/100ps

module smc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : smc_sync

//--- core/smc_sleep_ctrl.sv
/*
 * smc_sleep_ctrl: sleep mode controller with APB registers and per-peripheral clock stop.
 * Assumes wake sources and oscillator ready arrive asynchronously and that the clock
 * tree, oscillators and memories obey the enables it drives.
 */
// Functional notes
// - five software selectable sleep modes: idle, power-down, power-save, standby, extended.
// - idle halts CPU only; SRAM, events, interrupt controller, peripherals keep clocks.
// - power-down stops every oscillator, halting all clocked functions.
// - power-down keeps SRAM and register contents intact.
// - power-down wakes only on two-wire, USB resume, pin change or reset.
// - power-save is power-down plus running real-time counter and its oscillator.
// - standby keeps the crystal oscillator running for fast restart.
// - extended standby keeps main oscillator and real-time counter running.
// - in active and idle each peripheral clock can be stopped on its own.
`timescale 1ns/100ps

module smc_sleep_ctrl #(
    parameter int NPERIPH = smc_pkg::NUM_PERIPH
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [smc_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire smc_pkg::smc_wake_t          wake_in,
    input  wire logic                        osc_ready,
    output smc_pkg::smc_clk_t                clk_en,
    output logic      [NPERIPH-1:0]          periph_clk_en,
    output logic                             sleeping
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic smc_mode_legal(input logic [2:0] m);
        return (m == smc_pkg::MODE_IDLE) || (m == smc_pkg::MODE_PDOWN) ||
               (m == smc_pkg::MODE_PSAVE) || (m == smc_pkg::MODE_STDBY) ||
               (m == smc_pkg::MODE_ESTDBY);
    endfunction : smc_mode_legal

    // which synchronised wake sources end the given mode
    function automatic logic smc_wake_ok(input logic [2:0] m, input smc_pkg::smc_wake_t w);
        logic deep;
        deep = w.two_wire_serial_interface | w.usb_resume | w.pin_change;
        unique case (m)
            smc_pkg::MODE_IDLE:   return deep | w.rtc | w.any_irq;
            smc_pkg::MODE_PSAVE,
            smc_pkg::MODE_ESTDBY: return deep | w.rtc;
            default:              return deep;
        endcase
    endfunction : smc_wake_ok

    // enables for one state and mode
    function automatic smc_pkg::smc_clk_t smc_plan(input smc_pkg::smc_state_t s,
                                                   input logic [2:0] m);
        smc_pkg::smc_clk_t c;
        c = '0;
        unique case (s)
            smc_pkg::SMC_ACTIVE: c = smc_pkg::CLK_ALL_ON;
            smc_pkg::SMC_RESTART: begin
                // oscillators back on, core waits for them to settle
                c        = smc_pkg::CLK_ALL_ON;
                c.cpu    = 1'b0;
            end
            smc_pkg::SMC_SLEEP: begin
                unique case (m)
                    smc_pkg::MODE_IDLE: begin
                        c     = smc_pkg::CLK_ALL_ON;
                        c.cpu = 1'b0;
                    end
                    smc_pkg::MODE_PSAVE: begin
                        c.rtc_osc = 1'b1;
                        c.rtc     = 1'b1;
                    end
                    smc_pkg::MODE_STDBY: c.xtal_osc = 1'b1;
                    smc_pkg::MODE_ESTDBY: begin
                        c.main_osc = 1'b1;
                        c.rtc_osc  = 1'b1;
                        c.rtc      = 1'b1;
                    end
                    default: c.retain = 1'b1;
                endcase
                // set last so that idle, which starts from all-on, keeps retention too
                c.retain = 1'b1;
            end
        endcase
        return c;
    endfunction : smc_plan

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [2:0]              mode_sel;
    logic                    sleep_en;
    logic [2:0]              mode_run;
    logic [NPERIPH-1:0]      pgate;
    logic [smc_pkg::WAKE_W-1:0] wake_cause;
    smc_pkg::smc_state_t     state;
    smc_pkg::smc_state_t     next_state;
    smc_pkg::smc_wake_t      wake_s;
    logic                    osc_ready_s;
    logic [31:0]             next_prdata;
    logic                    hit;
    logic                    wr_acc;
    logic                    setup;
    logic                    sleep_req;
    logic                    wake_now;

    smc_sync #(
        .WIDTH    (smc_pkg::WAKE_W + 1)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({wake_in, osc_ready}),
        .sync_out ({wake_s, osc_ready_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign hit    = (paddr == smc_pkg::ADDR_CTRL)  || (paddr == smc_pkg::ADDR_SLEEP) ||
                    (paddr == smc_pkg::ADDR_PGATE) || (paddr == smc_pkg::ADDR_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        next_prdata = '0;
        unique case (paddr)
            smc_pkg::ADDR_CTRL: begin
                next_prdata[smc_pkg::CTRL_MODE_LO +: 3] = mode_sel;
                next_prdata[smc_pkg::CTRL_EN_BIT]       = sleep_en;
            end
            smc_pkg::ADDR_PGATE:  next_prdata[NPERIPH-1:0] = pgate;
            smc_pkg::ADDR_STATUS: begin
                next_prdata[smc_pkg::STAT_ST_LO +: 2]   = state;
                next_prdata[smc_pkg::STAT_MODE_LO +: 3] = mode_run;
                next_prdata[smc_pkg::STAT_WAKE_LO +: smc_pkg::WAKE_W] = wake_cause;
            end
            default: next_prdata = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // control register: mode select and sleep enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_sel <= smc_pkg::MODE_RESET;
            sleep_en <= smc_pkg::EN_RESET;
        end else if (wr_acc && paddr == smc_pkg::ADDR_CTRL) begin
            mode_sel <= pwdata[smc_pkg::CTRL_MODE_LO +: 3];
            sleep_en <= pwdata[smc_pkg::CTRL_EN_BIT];
        end
    end

    // a set bit stops that peripheral's clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pgate <= '0;
        end else if (wr_acc && paddr == smc_pkg::ADDR_PGATE) begin
            pgate <= pwdata[NPERIPH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sleep sequencer

    // an illegal mode or a cleared enable makes the request a no-op
    assign sleep_req = wr_acc && paddr == smc_pkg::ADDR_SLEEP && pwdata[smc_pkg::SLEEP_GO_BIT]
                       && sleep_en && smc_mode_legal(mode_sel);
    assign wake_now  = smc_wake_ok(mode_run, wake_s);

    always_comb begin
        next_state = state;
        unique case (state)
            smc_pkg::SMC_ACTIVE:  if (sleep_req) next_state = smc_pkg::SMC_SLEEP;
            smc_pkg::SMC_SLEEP:   if (wake_now) next_state = smc_pkg::SMC_RESTART;
            smc_pkg::SMC_RESTART: if (osc_ready_s) next_state = smc_pkg::SMC_ACTIVE;
            default:              next_state = smc_pkg::SMC_ACTIVE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= smc_pkg::SMC_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    // mode is frozen for the whole sleep so later writes cannot disturb it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_run <= smc_pkg::MODE_RESET;
        end else if (state == smc_pkg::SMC_ACTIVE && sleep_req) begin
            mode_run <= mode_sel;
        end
    end

    // records all synchronised sources seen in the cycle the last sleep ended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cause <= '0;
        end else if (state == smc_pkg::SMC_SLEEP && wake_now) begin
            wake_cause <= wake_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered enables toward the clock tree

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en   <= smc_pkg::CLK_ALL_ON;
            sleeping <= 1'b0;
        end else begin
            clk_en   <= smc_plan(next_state, mode_sel);
            if (next_state != smc_pkg::SMC_ACTIVE && state != smc_pkg::SMC_ACTIVE) begin
                clk_en <= smc_plan(next_state, mode_run);
            end
            sleeping <= (next_state == smc_pkg::SMC_SLEEP);
        end
    end

    // peripheral clocks run only in active and idle; idle keeps the software gates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_clk_en <= '1;
        end else if (next_state == smc_pkg::SMC_ACTIVE) begin
            periph_clk_en <= ~pgate;
        end else if (next_state == smc_pkg::SMC_SLEEP) begin
            periph_clk_en <= ((state == smc_pkg::SMC_ACTIVE ? mode_sel : mode_run)
                              == smc_pkg::MODE_IDLE) ? ~pgate : '0;
        end else begin
            periph_clk_en <= '0;
        end
    end

endmodule : smc_sleep_ctrl

//--- tb/smc_sleep_monitor.sv
/* smc_sleep_monitor: port-level checks of the sleep mode controller.
   Assumes it is bound into every smc_sleep_ctrl instance. */
`timescale 1ns/100ps

module smc_sleep_monitor #(
    parameter int NPERIPH = 16
) (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [smc_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0]               pwdata,
    input wire smc_pkg::smc_wake_t        wake_in,
    input wire logic                      osc_ready,
    input wire smc_pkg::smc_clk_t         clk_en,
    input wire logic [NPERIPH-1:0]        periph_clk_en,
    input wire logic                      sleeping
);
    logic               wr;
    logic               req;
    logic [3:0]         ctrl;
    logic [NPERIPH-1:0] pg;
    logic [2:0]         smode;

    assign wr  = psel && penable && pwrite;
    // restart is not active, so a request there must not count
    assign req = wr && paddr == smc_pkg::ADDR_SLEEP && pwdata[0] && ctrl[3]
                 && ctrl[2:0] <= 3'h4 && !sleeping && clk_en.cpu;

    // shadow copies keep the checker free of hierarchical peeks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 4'h0;
            pg   <= '0;
        end else if (wr && paddr == smc_pkg::ADDR_CTRL) begin
            ctrl <= pwdata[3:0];
        end else if (wr && paddr == smc_pkg::ADDR_PGATE) begin
            pg <= pwdata[NPERIPH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            smode <= 3'h0;
        else if (req)
            smode <= ctrl[2:0];
    end

////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pin; sleeping && wake_in.pin_change; endsequence
    sequence s_restart; osc_ready && !sleeping && !clk_en.cpu; endsequence

    property p_enter; req |=> sleeping && !clk_en.cpu && clk_en.retain; endproperty
    a_enter: assert property (p_enter) else $error("sleep not entered");
    property p_only_req; $rose(sleeping) |-> $past(req); endproperty
    a_only_req: assert property (p_only_req) else $error("sleep unrequested");
    property p_idle; sleeping && smode == smc_pkg::MODE_IDLE
        |-> clk_en == 9'h0FF && periph_clk_en == ~pg; endproperty
    a_idle: assert property (p_idle) else $error("idle enables wrong");
    property p_pdown; sleeping && smode == smc_pkg::MODE_PDOWN
        |-> clk_en == 9'h001 && periph_clk_en == '0; endproperty
    a_pdown: assert property (p_pdown) else $error("power-down enables wrong");
    property p_psave; sleeping && smode == smc_pkg::MODE_PSAVE |-> clk_en == 9'h007; endproperty
    a_psave: assert property (p_psave) else $error("power-save enables wrong");
    property p_stdby; sleeping && smode == smc_pkg::MODE_STDBY
        |-> clk_en.xtal_osc && !clk_en.cpu; endproperty
    a_stdby: assert property (p_stdby) else $error("standby enables wrong");
    property p_estdby; sleeping && smode == smc_pkg::MODE_ESTDBY
        |-> clk_en.main_osc && clk_en.rtc && !clk_en.cpu; endproperty
    a_estdby: assert property (p_estdby) else $error("ext standby enables wrong");
    property p_pd_wake; sleeping && smode == smc_pkg::MODE_PDOWN && wake_in[4:2] == 3'h0
        && $past(wake_in[4:2]) == 3'h0 |=> sleeping; endproperty
    a_pd_wake: assert property (p_pd_wake) else $error("power-down woke wrongly");
    property p_wake; s_pin [*2] |-> ##[1:4] !sleeping; endproperty
    a_wake: assert property (p_wake) else $error("no wake on pin change");
    property p_restore; s_restart [*3] |=> clk_en == smc_pkg::CLK_ALL_ON; endproperty
    a_restore: assert property (p_restore) else $error("clocks not restored");
    property p_gate; clk_en.cpu && !sleeping && pg == $past(pg)
        |-> periph_clk_en == ~pg; endproperty
    a_gate: assert property (p_gate) else $error("peripheral gate wrong");
endmodule : smc_sleep_monitor

bind smc_sleep_ctrl smc_sleep_monitor #(.NPERIPH(NPERIPH)) i_mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .wake_in, .osc_ready, .clk_en, .periph_clk_en, .sleeping
);

//--- tb/tb_top.sv
/* tb_top: self-checking bench for the sleep mode controller.
   Assumes the monitor binds itself from its own file. */
`timescale 1ns/100ps

module tb_top;
    logic               pclk;
    logic               presetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [7:0]         paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    smc_pkg::smc_wake_t wake_in;
    logic               osc_ready;
    smc_pkg::smc_clk_t  clk_en;
    logic [15:0]        periph_clk_en;
    logic               sleeping;
    logic [31:0]        rd;
    logic               er;
    int                 bad_count;
    int                 total_checks;

    smc_sleep_ctrl #(.NPERIPH(16)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .wake_in, .osc_ready, .clk_en, .periph_clk_en, .sleeping
    );

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("clk_en", 32'h1FE, clk_en);
        for (int i = 0; i < 16; i += 4) begin
            apb(1'b0, i[7:0], 32'h0);
            chk("reg", 32'h0, rd);
        end
        apb(1'b0, 8'h10, 32'h0);
        chk("pslverr", 32'h1, er);
    endtask : t_reset

    task automatic t_gate;
        apb(1'b1, smc_pkg::ADDR_PGATE, 32'h0000_00A5);
        apb(1'b0, smc_pkg::ADDR_PGATE, 32'h0);
        chk("pgate", 32'hA5, rd);
        chk("periph", 32'hFF5A, periph_clk_en);
    endtask : t_gate

    // sleep disabled, then an undefined mode code
    task automatic t_refuse(input logic [31:0] c);
        apb(1'b1, smc_pkg::ADDR_CTRL, c);
        apb(1'b1, smc_pkg::ADDR_SLEEP, 32'h1);
        repeat (3) @(posedge pclk);
        chk("sleeping", 32'h0, sleeping);
    endtask : t_refuse

    task automatic t_mode(input logic [2:0] m, input logic [8:0] ce,
                          input logic [4:0] bad, input logic [4:0] good);
        int n;
        apb(1'b1, smc_pkg::ADDR_CTRL, {28'h0, 1'b1, m});
        apb(1'b1, smc_pkg::ADDR_SLEEP, 32'h1);
        osc_ready <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("sleeping", 32'h1, sleeping);
        chk("clk_en", {23'h0, ce}, clk_en);
        chk("periph", m == 3'h0 ? 32'hFF5A : 32'h0, periph_clk_en);
        wake_in <= bad;
        repeat (6) @(posedge pclk);
        chk("kept asleep", 32'h1, sleeping);
        wake_in <= good;
        for (n = 0; n < 8 && sleeping !== 1'b0; n++) @(posedge pclk);
        chk("woken", 32'h0, sleeping);
        chk("cpu", 32'h0, clk_en.cpu);
        osc_ready <= 1'b1;
        wake_in <= 5'h00;
        for (n = 0; n < 8 && clk_en !== smc_pkg::CLK_ALL_ON; n++) @(posedge pclk);
        chk("restored", 32'h1FE, clk_en);
        chk("periph", 32'hFF5A, periph_clk_en);
        apb(1'b0, smc_pkg::ADDR_STATUS, 32'h0);
        chk("status", {19'h0, good, 1'b0, m, 4'h0}, rd);
        apb(1'b0, smc_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", {28'h0, 1'b1, m}, rd);
    endtask : t_mode

////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        finish_test();
    end

    initial begin
        presetn      = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0;
        wake_in      = 5'h00;
        osc_ready    = 1'b1;
        bad_count    = 0;
        total_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gate();
        t_refuse(32'h1);
        t_refuse(32'hD);
        t_mode(smc_pkg::MODE_IDLE, 9'h0FF, 5'h00, 5'h01);
        t_mode(smc_pkg::MODE_PDOWN, 9'h001, 5'h03, 5'h10);
        t_mode(smc_pkg::MODE_PSAVE, 9'h007, 5'h01, 5'h02);
        t_mode(smc_pkg::MODE_STDBY, 9'h009, 5'h03, 5'h08);
        t_mode(smc_pkg::MODE_ESTDBY, 9'h017, 5'h01, 5'h04);
        finish_test();
    end
endmodule : tb_top
